// ===== hdl/mgt_regs.svh
`ifndef MGT_REGS_SVH
`define MGT_REGS_SVH

// Bus addresses in 8-bit form (7-bit address shifted left, write bit clear)
`define MGT_BUS_ADDR_OPEN 8'h48
`define MGT_BUS_ADDR_GND 8'h10

// Active-address map
`define MGT_ADDR_FIELD 8'h00
`define MGT_ADDR_LOWER_TRIP 8'h20
`define MGT_ADDR_UPPER_TRIP 8'h21
`define MGT_ADDR_TRIP_DIFF 8'h22
`define MGT_ADDR_INVERT 8'h23
`define MGT_ADDR_LATCH_CLR 8'h30

// Parameter reset values
`define MGT_RST_LOWER_TRIP 8'h64
`define MGT_RST_UPPER_TRIP 8'hFF
`define MGT_RST_TRIP_DIFF 8'h0A
`define MGT_RST_INVERT 1'h0

// Code that selects latching in both differential and upper threshold
`define MGT_LATCH_CODE 8'hFF

// Bit counts and strap capture delay
`define MGT_BITS_PER_BYTE 4'h8
`define MGT_STRAP_WAIT 2'h3

`endif

// ===== hdl/mgt_pkg.sv
package mgt_pkg;

   // Bus-side protocol states
   typedef enum logic [2:0] {
      MGT_IDLE,
      MGT_ADDR,
      MGT_ACK_ADDR,
      MGT_WRITE,
      MGT_ACK_WRITE,
      MGT_READ,
      MGT_ACK_READ
   } mgt_bus_st_t;

   // One filtered field sample from the front end
   typedef struct packed {
      logic valid;
      logic [7:0] value;
   } mgt_sample_t;

   // Open-drain data pin as two signals
   typedef struct packed {
      logic out;
      logic oe;
   } mgt_od_drive_t;

   // Whole state of the readout block
   typedef struct packed {
      mgt_bus_st_t st;
      logic [3:0] bitcnt;
      logic [7:0] shreg;
      logic rw;
      logic pair_second;
      logic [7:0] act_addr;
      logic [7:0] field;
      logic [7:0] lower_threshold;
      logic [7:0] upper_threshold;
      logic [7:0] threshold_differential;
      logic invert;
      logic on;
      logic dout;
      mgt_od_drive_t sda_drv;
      logic [1:0] scl_s;
      logic [1:0] sda_s;
      logic scl_d;
      logic sda_d;
      logic [1:0] strap_cnt;
      logic alt_addr;
      logic [1:0] sel_s;
   } mgt_state_t;

endpackage : mgt_pkg

// ===== hdl/mgt_top.sv
`include "mgt_regs.svh"

// Functional notes
// - Device is bus target only, never controller
// - Address 48h open pin, 10h grounded
// - Invert flag set drives output inverted
// - Differential and upper 255 select latching
// - Latched output cleared by bus command only
// - On at threshold (only above it when latching), off below threshold minus differential
// - Compare field magnitude, either polarity
// - One-byte read returns active address value
// - Write bytes pair as address then data
// - Codes scaled 100 per 10, 10 per 1
// - Thresholds kept, output logic runs autonomously
// - Active address resets to zero, persists
// - Output starts unlatched in low-field state
module mgt_top (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Two-wire bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Address strap, low selects the alternate address
   input wire logic address_select_pin,
   // Filtered field samples, same clock domain
   input mgt_pkg::mgt_sample_t sample,
   // Threshold digital output
   output logic dout
);

   // Registered state and its next value
   mgt_pkg::mgt_state_t s_r;
   mgt_pkg::mgt_state_t s_nxt;

   // Read mux for the active address
   function automatic logic [7:0] read_byte(input mgt_pkg::mgt_state_t st, input logic [7:0] a);
      logic [7:0] v;
      v = 8'h00;
      unique case (a)
         `MGT_ADDR_FIELD: v = st.field;
         `MGT_ADDR_LOWER_TRIP: v = st.lower_threshold;
         `MGT_ADDR_UPPER_TRIP: v = st.upper_threshold;
         `MGT_ADDR_TRIP_DIFF: v = st.threshold_differential;
         `MGT_ADDR_INVERT: v = {7'h00, st.invert};
         default: v = 8'h00; // Unmapped addresses read zero
      endcase
      return v;
   endfunction : read_byte

   // Edge, start and stop detection from the synchronised pins
   logic scl;
   logic sda;
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   assign scl = s_r.scl_s[1];
   assign sda = s_r.sda_s[1];
   assign scl_rise = scl & ~s_r.scl_d;
   assign scl_fall = ~scl & s_r.scl_d;
   assign start_c = scl & s_r.scl_d & s_r.sda_d & ~sda;
   assign stop_c = scl & s_r.scl_d & ~s_r.sda_d & sda;

   // Field magnitude and turn-off level
   logic [7:0] mag;
   logic [7:0] off_level;
   logic latch_mode;
   logic [7:0] rd_val;
   assign mag = sample.value[7] ? 8'(-sample.value) : sample.value;
   // Saturate so a large differential cannot wrap the turn-off level
   assign off_level = (s_r.threshold_differential >= s_r.lower_threshold) ? 8'h00
                      : 8'(s_r.lower_threshold - s_r.threshold_differential);
   assign latch_mode = (s_r.threshold_differential == `MGT_LATCH_CODE)
                       && (s_r.upper_threshold == `MGT_LATCH_CODE);
   assign rd_val = read_byte(s_r, s_r.act_addr);

   // Next-state logic
   always_comb begin
      s_nxt = s_r;
      // Second stage only reads the first
      s_nxt.scl_s = {s_r.scl_s[0], scl_in};
      s_nxt.sda_s = {s_r.sda_s[0], sda_in};
      s_nxt.sel_s = {s_r.sel_s[0], address_select_pin};
      s_nxt.scl_d = scl;
      s_nxt.sda_d = sda;

      // Strap is read once, after the synchroniser has settled
      if (s_r.strap_cnt != `MGT_STRAP_WAIT) begin
         s_nxt.strap_cnt = s_r.strap_cnt + 2'h1;
         if (s_nxt.strap_cnt == `MGT_STRAP_WAIT) begin
            s_nxt.alt_addr = ~s_r.sel_s[1];
         end
      end

      // Target-only protocol engine; SCL is never driven
      if (start_c) begin
         s_nxt.st = mgt_pkg::MGT_ADDR;
         s_nxt.bitcnt = 4'h0;
         s_nxt.pair_second = 1'b0;
         s_nxt.sda_drv.oe = 1'b0;
      end else if (stop_c) begin
         s_nxt.st = mgt_pkg::MGT_IDLE;
         s_nxt.sda_drv.oe = 1'b0;
      end else begin
         unique case (s_r.st)
            mgt_pkg::MGT_IDLE: begin
               s_nxt.sda_drv.oe = 1'b0;
            end
            mgt_pkg::MGT_ADDR, mgt_pkg::MGT_WRITE: begin
               if (scl_rise && s_r.bitcnt != `MGT_BITS_PER_BYTE) begin
                  s_nxt.shreg = {s_r.shreg[6:0], sda};
                  s_nxt.bitcnt = s_r.bitcnt + 4'h1;
               end else if (scl_fall && s_r.bitcnt == `MGT_BITS_PER_BYTE) begin
                  if (s_r.st == mgt_pkg::MGT_ADDR) begin
                     // Match in 8-bit form; a miss leaves the bus alone
                     if ({s_r.shreg[7:1], 1'b0} ==
                         (s_r.alt_addr ? `MGT_BUS_ADDR_GND : `MGT_BUS_ADDR_OPEN)) begin
                        s_nxt.rw = s_r.shreg[0];
                        s_nxt.sda_drv.oe = 1'b1;
                        s_nxt.st = mgt_pkg::MGT_ACK_ADDR;
                     end else begin
                        s_nxt.st = mgt_pkg::MGT_IDLE;
                     end
                  end else begin
                     // First byte of a pair moves the pointer, second writes
                     if (!s_r.pair_second) begin
                        s_nxt.act_addr = s_r.shreg;
                     end else begin
                        unique case (s_r.act_addr)
                           `MGT_ADDR_LOWER_TRIP: s_nxt.lower_threshold = s_r.shreg;
                           `MGT_ADDR_UPPER_TRIP: s_nxt.upper_threshold = s_r.shreg;
                           `MGT_ADDR_TRIP_DIFF: s_nxt.threshold_differential = s_r.shreg;
                           `MGT_ADDR_INVERT: s_nxt.invert = s_r.shreg[0];
                           `MGT_ADDR_LATCH_CLR: s_nxt.on = 1'b0;
                           default: s_nxt.on = s_nxt.on; // Other writes ignored
                        endcase
                     end
                     s_nxt.pair_second = ~s_r.pair_second;
                     s_nxt.sda_drv.oe = 1'b1;
                     s_nxt.st = mgt_pkg::MGT_ACK_WRITE;
                  end
               end
            end
            mgt_pkg::MGT_ACK_ADDR: begin
               if (scl_fall) begin
                  s_nxt.bitcnt = 4'h0;
                  if (s_r.rw) begin
                     // Always valid data, so no polling needed
                     s_nxt.shreg = rd_val;
                     s_nxt.sda_drv.oe = ~rd_val[7];
                     s_nxt.st = mgt_pkg::MGT_READ;
                  end else begin
                     s_nxt.sda_drv.oe = 1'b0;
                     s_nxt.st = mgt_pkg::MGT_WRITE;
                  end
               end
            end
            mgt_pkg::MGT_ACK_WRITE: begin
               if (scl_fall) begin
                  s_nxt.sda_drv.oe = 1'b0;
                  s_nxt.bitcnt = 4'h0;
                  s_nxt.st = mgt_pkg::MGT_WRITE;
               end
            end
            mgt_pkg::MGT_READ: begin
               if (scl_rise) begin
                  s_nxt.bitcnt = s_r.bitcnt + 4'h1;
               end else if (scl_fall) begin
                  if (s_r.bitcnt == `MGT_BITS_PER_BYTE) begin
                     s_nxt.sda_drv.oe = 1'b0;
                     s_nxt.st = mgt_pkg::MGT_ACK_READ;
                  end else begin
                     s_nxt.shreg = {s_r.shreg[6:0], 1'b0};
                     s_nxt.sda_drv.oe = ~s_r.shreg[6];
                  end
               end
            end
            mgt_pkg::MGT_ACK_READ: begin
               // Controller ack repeats the same address; nack ends the read
               if (scl_rise) begin
                  s_nxt.rw = ~sda;
               end else if (scl_fall) begin
                  s_nxt.bitcnt = 4'h0;
                  if (s_r.rw) begin
                     s_nxt.shreg = rd_val;
                     s_nxt.sda_drv.oe = ~rd_val[7];
                     s_nxt.st = mgt_pkg::MGT_READ;
                  end else begin
                     s_nxt.st = mgt_pkg::MGT_IDLE;
                  end
               end
            end
         endcase
      end

      // Comparator, one decision per sample
      // Placed after the bus engine so a latching sample beats a clear in the same cycle
      if (sample.valid) begin
         s_nxt.field = mag;
         if (latch_mode) begin
            if (mag > s_r.lower_threshold) begin
               s_nxt.on = 1'b1;
            end
         end else if (mag >= s_r.lower_threshold) begin
            s_nxt.on = 1'b1;
         end else if (mag < off_level) begin
            s_nxt.on = 1'b0;
         end
      end

      // Output pin follows the decision and the polarity flag
      s_nxt.dout = s_nxt.on ^ s_nxt.invert;
   end

   // State register
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_r <= '0;
         s_r.st <= mgt_pkg::MGT_IDLE;
         s_r.act_addr <= `MGT_ADDR_FIELD;
         s_r.lower_threshold <= `MGT_RST_LOWER_TRIP;
         s_r.upper_threshold <= `MGT_RST_UPPER_TRIP;
         s_r.threshold_differential <= `MGT_RST_TRIP_DIFF;
         s_r.invert <= `MGT_RST_INVERT;
         s_r.on <= 1'b0;
         s_r.scl_s <= 2'h3;
         s_r.sda_s <= 2'h3;
         s_r.scl_d <= 1'b1;
         s_r.sda_d <= 1'b1;
         s_r.sel_s <= 2'h3;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from flops; data pin only ever pulls low
   assign sda_out = s_r.sda_drv.out;
   assign sda_oe = s_r.sda_drv.oe;
   assign dout = s_r.dout;

endmodule : mgt_top

// ===== testbench/mgt_top_monitor.sv
module mgt_top_monitor (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   // Strap, samples, output
   input wire logic address_select_pin,
   input mgt_pkg::mgt_sample_t sample,
   input wire logic dout
);
   timeunit 1ns;
   timeprecision 1ps;
   // All checks on the system clock, quiet during reset
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // Cycles since the clock pin fell, saturating
   logic [3:0] fall_cnt_r;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         fall_cnt_r <= 4'hF;
      end else if ($fell(scl_in)) begin
         fall_cnt_r <= 4'h0;
      end else if (fall_cnt_r != 4'hF) begin
         fall_cnt_r <= fall_cnt_r + 4'h1;
      end
   end
   chk_od_low: assert property (sda_out == 1'h0)
      else $error("sda_out not low");
   chk_oe_after_fall: assert property ($changed(sda_oe) |-> fall_cnt_r inside {[1:8]})
      else $error("sda_oe moved away from clock fall");
   chk_oe_hold: assert property ($rose(sda_oe) |=> sda_oe [*4])
      else $error("sda_oe pulse too short");
   chk_oe_scl_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
      else $error("sda_oe moved while clock high");
   chk_start_quiet: assert property ($fell(sda_in) && scl_in && $past(scl_in) |=> !sda_oe [*3])
      else $error("drive right after start");
   chk_stop_free: assert property ($rose(sda_in) && scl_in && $past(scl_in) |-> !sda_oe [*4])
      else $error("drive after stop");
   chk_dout_cause: assert property ($changed(dout) |->
      $past(sample.valid) || $past(sample.valid, 2) || fall_cnt_r < 4'hC)
      else $error("dout moved without cause");
   chk_dout_quiet: assert property ((!sample.valid && scl_in) [*8] |=> $stable(dout))
      else $error("dout moved while idle");
   // Main scenarios
   cover property ($rose(dout));
   cover property ($fell(dout));
   cover property ($rose(sda_oe));
endmodule : mgt_top_monitor

bind mgt_top mgt_top_monitor mgt_top_monitor_inst (.clk(clk), .reset(reset), .scl_in(scl_in),
   .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
   .address_select_pin(address_select_pin), .sample(sample), .dout(dout));

// ===== testbench/mgt_i2c_master.sv
module mgt_i2c_master (
   // Clock
   input wire logic clk,
   // Bus lines, high means released
   output logic scl,
   output logic sda_drv,
   input wire logic sda_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle bus is released
   initial begin
      scl = 1'h1;
      sda_drv = 1'h1;
   end
   // Quarter bit steps; a long low phase leaves the target time to drive
   task automatic tick();
      repeat (10) @(posedge clk);
      #2;
   endtask : tick
   // Only this side makes the clock
   task automatic start();
      sda_drv = 1'h1;
      tick();
      scl = 1'h1;
      tick();
      sda_drv = 1'h0;
      tick();
      scl = 1'h0;
      tick();
   endtask : start
   task automatic stop();
      sda_drv = 1'h0;
      tick();
      scl = 1'h1;
      tick();
      sda_drv = 1'h1;
      tick();
   endtask : stop
   // Data held over the whole high phase
   task automatic bit_io(input logic b, output logic r);
      sda_drv = b;
      tick();
      scl = 1'h1;
      tick();
      r = sda_in;
      tick();
      scl = 1'h0;
      tick();
   endtask : bit_io
   // Eight bits MSB first, then the ninth bit
   task automatic byte_io(input logic [7:0] tx, input logic last, output logic [7:0] rx,
      output logic a9);
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], rx[i]);
      end
      bit_io(last, a9);
   endtask : byte_io
endmodule : mgt_i2c_master

// ===== testbench/magnetometer_i2c_threshold_output_tb.sv
module magnetometer_i2c_threshold_output_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int NV_WAIT = 200; // Shortened programming wait
   logic clk, reset, scl, sda_drv, sda_w, strap, dout, sda_out, sda_oe;
   mgt_pkg::mgt_sample_t sample;
   logic [7:0] bus_a;
   int err_total, total_checks;
   // Pulled-up open-drain data wire
   assign sda_w = sda_drv & ~(sda_oe & ~sda_out);
   mgt_top mgt_top_inst (.clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda_w),
      .sda_out(sda_out), .sda_oe(sda_oe), .address_select_pin(strap), .sample(sample),
      .dout(dout));
   mgt_i2c_master mgt_i2c_master_inst (.clk(clk), .scl(scl), .sda_drv(sda_drv), .sda_in(sda_w));
   initial begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic end_sim();
      if (err_total == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_sim
   task automatic rst();
      reset = 1'h1;
      repeat (8) @(posedge clk);
      #2;
      reset = 1'h0;
      repeat (6) @(posedge clk);
      #2;
   endtask : rst
   // Programming wait after a parameter write, shortened
   task automatic nvw();
      repeat (NV_WAIT) @(posedge clk);
      #2;
   endtask : nvw
   // Write n bytes; ackx is the expected address ack
   task automatic wrq(input logic [7:0] b [4], input int n, input logic ackx);
      logic [7:0] rx;
      logic a;
      mgt_i2c_master_inst.start();
      mgt_i2c_master_inst.byte_io(bus_a, 1'h1, rx, a);
      chk({7'h00, ~a}, {7'h00, ackx}, "address ack");
      for (int i = 0; i < n && ackx; i++) begin
         mgt_i2c_master_inst.byte_io(b[i], 1'h1, rx, a);
         chk({7'h00, a}, 8'h00, "data ack");
      end
      mgt_i2c_master_inst.stop();
   endtask : wrq
   // n bytes from the current active address; master acks all but the last
   task automatic rdc(input logic [7:0] exp, input string what, input int n = 1);
      logic [7:0] rx;
      logic a;
      mgt_i2c_master_inst.start();
      mgt_i2c_master_inst.byte_io(bus_a | 8'h01, 1'h1, rx, a);
      for (int i = 0; i < n; i++) begin
         mgt_i2c_master_inst.byte_io(8'hFF, i == n - 1, rx, a);
         chk(rx, exp, what);
      end
      mgt_i2c_master_inst.stop();
   endtask : rdc
   task automatic rd(input logic [7:0] p, input logic [7:0] exp, input string what);
      wrq('{p, 8'h00, 8'h00, 8'h00}, 1, 1'h1);
      rdc(exp, what);
   endtask : rd
   // One sample pulse, then dout compared
   task automatic smp(input logic [7:0] val, input logic exp);
      sample = '{1'h1, val};
      @(posedge clk);
      #2;
      sample.valid = 1'h0;
      repeat (3) @(posedge clk);
      #2;
      chk({7'h00, dout}, {7'h00, exp}, "dout");
   endtask : smp
   initial begin
      err_total = 0;
      total_checks = 0;
      strap = 1'h1;
      sample = '0;
      bus_a = 8'h48;
      rst();
      chk({7'h00, dout}, 8'h00, "dout after reset");
      smp(8'hCE, 1'h0);
      rdc(8'h32, "field");
      smp(8'h64, 1'h1);
      smp(8'h5A, 1'h1);
      smp(8'h59, 1'h0);
      smp(8'h9C, 1'h1);
      smp(8'h00, 1'h0);
      rd(8'h20, 8'h64, "lower trip");
      rd(8'h22, 8'h0A, "trip diff");
      wrq('{8'h20, 8'h40, 8'h22, 8'h05}, 4, 1'h1);
      nvw();
      rd(8'h20, 8'h40, "lower trip");
      rd(8'h22, 8'h05, "trip diff");
      rdc(8'h05, "trip diff again", 2);
      smp(8'h40, 1'h1);
      smp(8'h3B, 1'h1);
      smp(8'h3A, 1'h0);
      wrq('{8'h23, 8'h01, 8'h00, 8'h00}, 2, 1'h1);
      nvw();
      chk({7'h00, dout}, 8'h01, "dout inverted");
      rd(8'h23, 8'h01, "invert flag");
      smp(8'h40, 1'h0);
      smp(8'h00, 1'h1);
      wrq('{8'h22, 8'hFF, 8'h21, 8'hFF}, 4, 1'h1);
      nvw();
      rd(8'h21, 8'hFF, "upper trip");
      smp(8'h40, 1'h1);
      smp(8'h41, 1'h0);
      smp(8'h00, 1'h0);
      wrq('{8'h30, 8'h00, 8'h00, 8'h00}, 2, 1'h1);
      chk({7'h00, dout}, 8'h01, "dout cleared");
      rd(8'h31, 8'h00, "unmapped");
      bus_a = 8'h10;
      wrq('{8'h00, 8'h00, 8'h00, 8'h00}, 0, 1'h0);
      strap = 1'h0;
      rst();
      chk({7'h00, dout}, 8'h00, "dout after reset");
      rd(8'h20, 8'h64, "lower trip");
      bus_a = 8'h48;
      wrq('{8'h00, 8'h00, 8'h00, 8'h00}, 0, 1'h0);
      end_sim();
   end
   // Hang guard, well past the expected run
   initial begin
      repeat (90000) @(posedge clk);
      err_total++;
      end_sim();
   end
endmodule : magnetometer_i2c_threshold_output_tb
